// ==== verilog/ujd_jump_decode.v ====
// Notes on behaviour
// - The relative feedback jump takes the offset when the selected feedback matches Pol.
// - Offsets are 5-bit two's complement, -16..15, added to the jump instruction's address.
// - Selector codes 0000..1001 pick high-side 1..5, even code drain-source, odd code source.
// - Selector codes 1010..1111 pick low-side 1..6 drain-source feedback in order.
// - Polarity 0 is true on a low signal, polarity 1 on a high signal.
// - The unconditional far jump always loads the PC from the selected jump register.
// - The far jump is bits 15..4 = 001110011010 and 2..0 = 101 with register select at 3.
// - The unconditional relative jump always adds the signed offset to the PC.
// - The condition far jump loads the jump register when the 6-bit condition holds.
// - Condition codes cover flags low and high, terminal counts 1..4 and start low/high.
// - Codes 100110..101110 test the shortcut drain-source and source feedbacks.
// - Code 101111 is ALU request done, 110000 boost high, 110001 boost low.
// - Codes 110010..111111 test the current feedbacks and the core's own, high then low.
`timescale 1ns/1ps
`include "ujd_consts.vh"

module ujd_jump_decode (
	// Clock and reset
	input wire clk_i,
	input wire nrst_i,
	// Fetched instruction, located at the current program counter
	input wire instr_valid_i,
	input wire [15:0] instr_i,
	// Jump register file, same clock
	input wire [`UJD_PC_W-1:0] jump_reg0_i,
	input wire [`UJD_PC_W-1:0] jump_reg1_i,
	// Jump requested by neighbouring decoders, same clock
	input wire ext_jump_i,
	input wire [`UJD_PC_W-1:0] ext_target_i,
	// Pre-driver feedback pins, asynchronous
	input wire [4:0] hs_vds_fb_i,
	input wire [4:0] hs_src_fb_i,
	input wire [5:0] ls_vds_fb_i,
	// Condition sources from pins, asynchronous
	input wire start_i,
	input wire [2:0] sc_vds_i,
	input wire [2:0] sc_src_i,
	input wire boost_high_i,
	input wire [5:0] cur_fb_i,
	input wire own_cur_i,
	// Condition sources from core logic, same clock
	input wire [15:0] flags_i,
	input wire [3:0] term_count_i,
	input wire alu_done_i,
	// Program counter and status
	output wire [`UJD_PC_W-1:0] core_program_counter_o,
	output wire jump_taken_o,
	output wire [2:0] jump_kind_o,
	output wire cond_seen_o
);

	// Registers
	reg [`UJD_PC_W-1:0] pc_reg;
	reg [`UJD_PC_W-1:0] pc_next;
	reg taken_reg;
	reg taken_next;
	reg [2:0] kind_reg;
	reg [2:0] kind_next;
	reg cond_seen_reg;
	reg cond_seen_next;
	reg [`UJD_SYNC_W-1:0] sync1_reg;
	reg [`UJD_SYNC_W-1:0] sync2_reg;

	// Decode results, combinational
	reg [2:0] pc_src;
	reg [2:0] kind_dec;
	reg test_dec;

	// Decode and datapath nets
	wire [`UJD_SYNC_W-1:0] pins_raw;
	wire [4:0] hs_vds_s;
	wire [4:0] hs_src_s;
	wire [5:0] ls_vds_s;
	wire start_s;
	wire [2:0] sc_vds_s;
	wire [2:0] sc_src_s;
	wire boost_high_s;
	wire [5:0] cur_fb_s;
	wire own_cur_s;
	wire [15:0] fbk_vec;
	wire is_fbkr;
	wire is_jmpf;
	wire is_jmpr;
	wire is_jocf;
	wire [`UJD_OFS_W-1:0] offset;
	wire [`UJD_PC_W-1:0] offset_ext;
	wire [`UJD_PC_W-1:0] pc_rel;
	wire [`UJD_PC_W-1:0] pc_seq;
	wire [3:0] fbk_sel;
	wire fbk_pol;
	wire fbk_bit;
	wire fbk_hit;
	wire [5:0] cond_code;
	wire cond_true;
	wire jmpf_reg_sel;
	wire jocf_reg_sel;
	wire far_reg_sel;
	wire [`UJD_PC_W-1:0] far_target;

	// Bundle every pin-side input for the synchroniser
	assign pins_raw = {hs_vds_fb_i, hs_src_fb_i, ls_vds_fb_i, start_i, sc_vds_i,
		sc_src_i, boost_high_i, cur_fb_i, own_cur_i};

	// Two-stage synchroniser; only sync2_reg is read by logic
	// Costs two cycles of latency on every pin test, traded for no metastable decisions
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_reg <= {`UJD_SYNC_W{1'b0}};
			sync2_reg <= {`UJD_SYNC_W{1'b0}};
		end else begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
		end
	end

	// Unpack the synchronised bundle in the same order as it was packed
	assign {hs_vds_s, hs_src_s, ls_vds_s, start_s, sc_vds_s, sc_src_s, boost_high_s,
		cur_fb_s, own_cur_s} = sync2_reg;

	// Feedback vector indexed by selector code
	genvar i;
	generate
		for (i = 0; i < 5; i = i + 1) begin : g_hs
			assign fbk_vec[2 * i] = hs_vds_s[i];
			assign fbk_vec[2 * i + 1] = hs_src_s[i];
		end
		for (i = 0; i < 6; i = i + 1) begin : g_ls
			assign fbk_vec[10 + i] = ls_vds_s[i];
		end
	endgenerate

	// Opcode recognition; the four patterns are mutually exclusive
	assign is_fbkr = (instr_i & `UJD_FBKR_MASK) == `UJD_FBKR_VAL;
	assign is_jmpf = (instr_i & `UJD_JMPF_MASK) == `UJD_JMPF_VAL;
	assign is_jmpr = (instr_i & `UJD_JMPR_MASK) == `UJD_JMPR_VAL;
	assign is_jocf = (instr_i & `UJD_JOCF_MASK) == `UJD_JOCF_VAL;

	// Signed offset, sign bit copied across the upper address bits
	assign offset = instr_i[`UJD_OFS_MSB:0];
	assign offset_ext = {{(`UJD_PC_W - `UJD_OFS_W){offset[`UJD_OFS_W-1]}}, offset};
	// Relative to the jump's own address; wraps modulo the Code RAM size
	assign pc_rel = pc_reg + offset_ext;
	assign pc_seq = pc_reg + {{(`UJD_PC_W - 1){1'b0}}, 1'b1};

	// Feedback test with polarity
	assign fbk_sel = instr_i[`UJD_FBKR_SEL_MSB:`UJD_FBKR_SEL_LSB];
	assign fbk_pol = instr_i[`UJD_FBKR_POL_BIT];
	assign fbk_bit = fbk_vec[fbk_sel];
	assign fbk_hit = ~(fbk_bit ^ fbk_pol);

	// Condition code evaluation
	assign cond_code = instr_i[`UJD_JOCF_COND_MSB:`UJD_JOCF_COND_LSB];

	ujd_cond_mux u_cond (
		.cond_code_i(cond_code),
		.flags_i(flags_i),
		.term_count_i(term_count_i),
		.start_i(start_s),
		.sc_vds_i(sc_vds_s),
		.sc_src_i(sc_src_s),
		.alu_done_i(alu_done_i),
		.boost_high_i(boost_high_s),
		.cur_fb_i(cur_fb_s),
		.own_cur_i(own_cur_s),
		.cond_true_o(cond_true)
	);

	// Jump register pick; the select bit sits at a different place per opcode
	assign jmpf_reg_sel = instr_i[`UJD_JMPF_REG_BIT];
	assign jocf_reg_sel = instr_i[`UJD_JOCF_REG_BIT];
	assign far_reg_sel = is_jmpf ? jmpf_reg_sel : jocf_reg_sel;
	assign far_target = far_reg_sel ? jump_reg1_i : jump_reg0_i;

	// Counter source codes; hold and step are the two non-jump choices
	localparam SRC_HOLD = 3'h0;
	localparam SRC_SEQ = 3'h1;
	localparam SRC_REL = 3'h2;
	localparam SRC_FAR = 3'h3;
	localparam SRC_EXT = 3'h4;

	// Decode stage; the if chain is the priority order, local jumps before the hook
	always @* begin
		pc_src = SRC_HOLD;
		kind_dec = `UJD_KIND_NONE;
		test_dec = 1'b0;
		if (!instr_valid_i) begin
			pc_src = SRC_HOLD; // Nothing moves without a valid instruction
		end else if (is_fbkr) begin
			kind_dec = `UJD_KIND_FBKR;
			test_dec = fbk_hit;
			pc_src = fbk_hit ? SRC_REL : SRC_SEQ;
		end else if (is_jmpf) begin
			kind_dec = `UJD_KIND_JMPF;
			pc_src = SRC_FAR;
		end else if (is_jmpr) begin
			kind_dec = `UJD_KIND_JMPR;
			pc_src = SRC_REL;
		end else if (is_jocf) begin
			kind_dec = `UJD_KIND_JOCF;
			test_dec = cond_true;
			pc_src = cond_true ? SRC_FAR : SRC_SEQ;
		end else if (ext_jump_i) begin
			// Other jump forms are decoded elsewhere and only hand over a target
			kind_dec = `UJD_KIND_EXT;
			pc_src = SRC_EXT;
		end else begin
			pc_src = SRC_SEQ;
		end
	end

	// Counter mux
	always @* begin
		case (pc_src)
			SRC_HOLD: begin
				pc_next = pc_reg;
			end
			SRC_SEQ: begin
				pc_next = pc_seq;
			end
			SRC_REL: begin
				pc_next = pc_rel;
			end
			SRC_FAR: begin
				pc_next = far_target;
			end
			SRC_EXT: begin
				pc_next = ext_target_i;
			end
			default: begin
				pc_next = pc_reg; // Unused codes hold rather than jump somewhere random
			end
		endcase
	end

	// A jump is any source other than holding or stepping
	always @* begin
		case (pc_src)
			SRC_REL: begin
				taken_next = 1'b1;
			end
			SRC_FAR: begin
				taken_next = 1'b1;
			end
			SRC_EXT: begin
				taken_next = 1'b1;
			end
			default: begin
				taken_next = 1'b0;
			end
		endcase
	end

	// Kind and test result follow a valid word and hold between words
	always @* begin
		kind_next = kind_reg;
		cond_seen_next = cond_seen_reg;
		if (instr_valid_i) begin
			kind_next = kind_dec;
			cond_seen_next = test_dec;
		end
	end

	// Program counter; reset puts the core back at the first Code RAM word
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pc_reg <= `UJD_PC_RST;
		end else begin
			pc_reg <= pc_next;
		end
	end

	// Taken pulse, one cycle per jump
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			taken_reg <= 1'b0;
		end else begin
			taken_reg <= taken_next;
		end
	end

	// Kind of the last valid word
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			kind_reg <= `UJD_KIND_NONE;
		end else begin
			kind_reg <= kind_next;
		end
	end

	// Test result of the last valid word; 0 unless that word was a feedback or condition jump
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cond_seen_reg <= 1'b0;
		end else begin
			cond_seen_reg <= cond_seen_next;
		end
	end

	// Outputs straight from flip-flops
	assign core_program_counter_o = pc_reg;
	assign jump_taken_o = taken_reg;
	assign jump_kind_o = kind_reg;
	assign cond_seen_o = cond_seen_reg;

endmodule

// ==== verilog/ujd_consts.vh ====
`ifndef UJD_CONSTS_VH
`define UJD_CONSTS_VH

// Code RAM address width and program counter reset value
`define UJD_PC_W 10
`define UJD_PC_RST 10'h000

// Relative jump on feedback: bits 15..10 fixed, Pol at 9, selector 8..5, offset 4..0
`define UJD_FBKR_MASK 16'hFC00
`define UJD_FBKR_VAL 16'h2800

// Unconditional far jump: 15..4 = 001110011010, 2..0 = 101, register select at 3
`define UJD_JMPF_MASK 16'hFFF7
`define UJD_JMPF_VAL 16'h39A5

// Unconditional relative jump: 15..5 = 00101111000, offset 4..0
`define UJD_JMPR_MASK 16'hFFE0
`define UJD_JMPR_VAL 16'h2F00

// Far jump on condition: 15..11 = 00111, 3..0 = 0000, condition 10..5, register select 4
`define UJD_JOCF_MASK 16'hF80F
`define UJD_JOCF_VAL 16'h3800

// Field positions
`define UJD_OFS_MSB 4
`define UJD_OFS_W 5
`define UJD_FBKR_POL_BIT 9
`define UJD_FBKR_SEL_MSB 8
`define UJD_FBKR_SEL_LSB 5
`define UJD_JMPF_REG_BIT 3
`define UJD_JOCF_COND_MSB 10
`define UJD_JOCF_COND_LSB 5
`define UJD_JOCF_REG_BIT 4

// Instruction kind reported on jump_kind_o
`define UJD_KIND_NONE 3'h0
`define UJD_KIND_FBKR 3'h1
`define UJD_KIND_JMPF 3'h2
`define UJD_KIND_JMPR 3'h3
`define UJD_KIND_JOCF 3'h4
`define UJD_KIND_EXT 3'h5

// Condition code groups
`define UJD_CC_TC_BASE 6'h20
`define UJD_CC_START_LOW 6'h24
`define UJD_CC_START_HIGH 6'h25
`define UJD_CC_SCV_LOW 6'h26
`define UJD_CC_SCS_LOW 6'h29
`define UJD_CC_SCV_HIGH 6'h2C
`define UJD_CC_ALU_DONE 6'h2F
`define UJD_CC_VB_HIGH 6'h30
`define UJD_CC_VB_LOW 6'h31
`define UJD_CC_CUR_HIGH 6'h32
`define UJD_CC_CUR_LOW 6'h38
`define UJD_CC_OWN_HIGH 6'h3E
`define UJD_CC_OWN_LOW 6'h3F

// Width of the synchronised pin bundle
`define UJD_SYNC_W 31

`endif

// ==== verilog/ujd_cond_mux.v ====
`timescale 1ns/1ps
`include "ujd_consts.vh"

// Evaluates the 6-bit condition code of the far-on-condition jump.
// All inputs arrive already synchronised or from logic on the same clock.
module ujd_cond_mux (
	// Condition select
	input wire [5:0] cond_code_i,
	// Condition sources
	input wire [15:0] flags_i,
	input wire [3:0] term_count_i,
	input wire start_i,
	input wire [2:0] sc_vds_i,
	input wire [2:0] sc_src_i,
	input wire alu_done_i,
	input wire boost_high_i,
	input wire [5:0] cur_fb_i,
	input wire own_cur_i,
	// Result
	output wire cond_true_o
);

	wire [63:0] cond_vec;

	genvar n;

	// Flag n low at code n, flag n high at code 16 plus n
	generate
		for (n = 0; n < 16; n = n + 1) begin : g_flag
			assign cond_vec[n] = ~flags_i[n];
			assign cond_vec[16 + n] = flags_i[n];
		end
	endgenerate

	// Terminal counts and start line
	assign cond_vec[`UJD_CC_TC_BASE + 3:`UJD_CC_TC_BASE] = term_count_i;
	assign cond_vec[`UJD_CC_START_LOW] = ~start_i;
	assign cond_vec[`UJD_CC_START_HIGH] = start_i;

	// Shortcut feedbacks, three channels per group
	assign cond_vec[`UJD_CC_SCV_LOW + 2:`UJD_CC_SCV_LOW] = ~sc_vds_i;
	assign cond_vec[`UJD_CC_SCS_LOW + 2:`UJD_CC_SCS_LOW] = ~sc_src_i;
	assign cond_vec[`UJD_CC_SCV_HIGH + 2:`UJD_CC_SCV_HIGH] = sc_vds_i;

	// ALU completion and boost voltage
	assign cond_vec[`UJD_CC_ALU_DONE] = alu_done_i;
	assign cond_vec[`UJD_CC_VB_HIGH] = boost_high_i;
	assign cond_vec[`UJD_CC_VB_LOW] = ~boost_high_i;

	// Current feedbacks 1, 2, 3, 4l, 4h, 4n and the core's own
	assign cond_vec[`UJD_CC_CUR_HIGH + 5:`UJD_CC_CUR_HIGH] = cur_fb_i;
	assign cond_vec[`UJD_CC_CUR_LOW + 5:`UJD_CC_CUR_LOW] = ~cur_fb_i;
	assign cond_vec[`UJD_CC_OWN_HIGH] = own_cur_i;
	assign cond_vec[`UJD_CC_OWN_LOW] = ~own_cur_i;

	assign cond_true_o = cond_vec[cond_code_i];

endmodule

// ==== test/ujd_jump_monitor.sv ====
`timescale 1ns/1ps
`include "ujd_consts.vh"
module ujd_jump_monitor (
	// Clock, reset and instruction side
	input wire clk_i,
	input wire nrst_i,
	input wire instr_valid_i,
	input wire [15:0] instr_i,
	input wire [9:0] jump_reg0_i,
	input wire [9:0] jump_reg1_i,
	input wire ext_jump_i,
	input wire [9:0] ext_target_i,
	// Observed outputs
	input wire [9:0] core_program_counter_o,
	input wire jump_taken_o,
	input wire [2:0] jump_kind_o,
	input wire cond_seen_o
);
	// Decode of the four local jump words, only while an instruction is offered
	wire is_jmpr = instr_valid_i && ((instr_i & `UJD_JMPR_MASK) == `UJD_JMPR_VAL);
	wire is_jmpf = instr_valid_i && ((instr_i & `UJD_JMPF_MASK) == `UJD_JMPF_VAL);
	wire is_fbkr = instr_valid_i && ((instr_i & `UJD_FBKR_MASK) == `UJD_FBKR_VAL);
	wire is_jocf = instr_valid_i && ((instr_i & `UJD_JOCF_MASK) == `UJD_JOCF_VAL);
	wire hit = is_jmpr || is_jmpf || is_fbkr || is_jocf;
	// Candidate targets, sampled one cycle back by the properties
	wire [9:0] rel_tgt = core_program_counter_o + {{5{instr_i[4]}}, instr_i[4:0]};
	wire [9:0] step_tgt = core_program_counter_o + 10'h001;
	wire [9:0] f_reg = instr_i[3] ? jump_reg1_i : jump_reg0_i;
	wire [9:0] c_reg = instr_i[4] ? jump_reg1_i : jump_reg0_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_jmpr;
		is_jmpr;
	endsequence
	sequence s_land_rel;
		core_program_counter_o == $past(rel_tgt) && jump_taken_o;
	endsequence
	chk_jmpr_target: assert property (s_jmpr |=> s_land_rel)
		else $error("relative jump landed wrong");
	chk_jmpr_kind: assert property (s_jmpr |=> jump_kind_o == `UJD_KIND_JMPR && !cond_seen_o)
		else $error("relative jump kind wrong");
	chk_jmpf_target: assert property (is_jmpf |=>
		core_program_counter_o == $past(f_reg) && jump_taken_o && jump_kind_o == `UJD_KIND_JMPF)
		else $error("far jump target wrong");
	chk_fbkr_pick: assert property (is_fbkr |=>
		jump_taken_o == cond_seen_o && core_program_counter_o
		== (cond_seen_o ? $past(rel_tgt) : $past(step_tgt)))
		else $error("feedback jump target wrong");
	chk_jocf_pick: assert property (is_jocf |=>
		jump_taken_o == cond_seen_o && core_program_counter_o
		== (cond_seen_o ? $past(c_reg) : $past(step_tgt)))
		else $error("condition jump target wrong");
	chk_idle_hold: assert property (!instr_valid_i |=> $stable(core_program_counter_o) && !jump_taken_o)
		else $error("counter moved while idle");
	chk_ext_jump: assert property (instr_valid_i && !hit && ext_jump_i |=>
		core_program_counter_o == $past(ext_target_i) && jump_kind_o == `UJD_KIND_EXT)
		else $error("outside jump wrong");
	chk_plain_step: assert property (instr_valid_i && !hit && !ext_jump_i |=>
		core_program_counter_o == $past(step_tgt) && !jump_taken_o)
		else $error("plain step wrong");
endmodule

// ==== test/tb_ucore_jump_instruction_decode.sv ====
`timescale 1ns/1ps
module tb_ucore_jump_instruction_decode;
	reg clk_i, nrst_i, instr_valid_i, ext_jump_i, start_i, boost_high_i, own_cur_i, alu_done_i, c;
	reg [15:0] instr_i, flags_i, w;
	reg [9:0] jump_reg0_i, jump_reg1_i, ext_target_i, pc;
	reg [4:0] hs_vds_fb_i, hs_src_fb_i;
	reg [5:0] ls_vds_fb_i, cur_fb_i;
	reg [2:0] sc_vds_i, sc_src_i;
	reg [3:0] term_count_i;
	reg [31:0] seed;
	wire [9:0] core_program_counter_o;
	wire jump_taken_o, cond_seen_o;
	wire [2:0] jump_kind_o;
	integer failures, cmp_count, i;
	ujd_jump_decode dut (.clk_i(clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
		.instr_i(instr_i), .jump_reg0_i(jump_reg0_i), .jump_reg1_i(jump_reg1_i),
		.ext_jump_i(ext_jump_i), .ext_target_i(ext_target_i), .hs_vds_fb_i(hs_vds_fb_i),
		.hs_src_fb_i(hs_src_fb_i), .ls_vds_fb_i(ls_vds_fb_i), .start_i(start_i),
		.sc_vds_i(sc_vds_i), .sc_src_i(sc_src_i), .boost_high_i(boost_high_i),
		.cur_fb_i(cur_fb_i), .own_cur_i(own_cur_i), .flags_i(flags_i),
		.term_count_i(term_count_i), .alu_done_i(alu_done_i),
		.core_program_counter_o(core_program_counter_o), .jump_taken_o(jump_taken_o),
		.jump_kind_o(jump_kind_o), .cond_seen_o(cond_seen_o));
	// Free-running 10 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	// Expected feedback level picked by the selector
	function fb_sel(input [3:0] s);
		fb_sel = (s < 10) ? (s[0] ? hs_src_fb_i[s >> 1] : hs_vds_fb_i[s >> 1]) : ls_vds_fb_i[s - 10];
	endfunction
	// Expected truth of a condition code, table order
	function cc_eval(input [5:0] k);
		begin
			if (k < 16) cc_eval = !flags_i[k];
			else if (k < 32) cc_eval = flags_i[k - 16];
			else if (k < 36) cc_eval = term_count_i[k - 32];
			else if (k < 38) cc_eval = start_i == k[0];
			else if (k < 41) cc_eval = !sc_vds_i[k - 38];
			else if (k < 44) cc_eval = !sc_src_i[k - 41];
			else if (k < 47) cc_eval = sc_vds_i[k - 44];
			else if (k == 47) cc_eval = alu_done_i;
			else if (k < 50) cc_eval = boost_high_i != k[0];
			else if (k < 56) cc_eval = cur_fb_i[k - 50];
			else if (k < 62) cc_eval = !cur_fb_i[k - 56];
			else cc_eval = own_cur_i != k[0];
		end
	endfunction
	function [9:0] rel(input [15:0] x);
		rel = pc + {{5{x[4]}}, x[4:0]};
	endfunction
	task check(input string nm, input [15:0] seen, input [15:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// New random pins and sources; core idles over the two synchroniser edges
	task shuffle;
		begin
			@(negedge clk_i);
			instr_valid_i = 1'b0;
			seed = xs(seed);
			{hs_vds_fb_i, hs_src_fb_i, ls_vds_fb_i, start_i, sc_vds_i, sc_src_i, boost_high_i,
				cur_fb_i, own_cur_i} = seed[30:0];
			seed = xs(seed);
			{flags_i, term_count_i, alu_done_i, ext_jump_i, ext_target_i} = seed;
			seed = xs(seed);
			{jump_reg0_i, jump_reg1_i} = seed[19:0];
			repeat (2) @(posedge clk_i);
		end
	endtask
	task exec(input [15:0] x, input tk, input [9:0] tgt, input [2:0] kd, input cs);
		begin
			@(negedge clk_i);
			instr_valid_i = 1'b1;
			instr_i = x;
			@(posedge clk_i);
			#1;
			pc = tk ? tgt : pc + 10'h001;
			check("pc", core_program_counter_o, pc);
			check("taken", jump_taken_o, tk);
			check("kind", jump_kind_o, kd);
			check("cond", cond_seen_o, cs);
		end
	endtask
	task print_verdict;
		begin
			$display("compares %0d failures %0d", cmp_count, failures);
			if (failures == 0 && cmp_count > 0) $display("STATUS OK");
			else $display("STATUS NOT OK");
			$finish;
		end
	endtask
	// Watchdog sized well above the roughly 530 cycles of traffic
	initial begin
		#400000;
		failures = failures + 1;
		print_verdict;
	end
	initial begin
		{instr_valid_i, ext_jump_i, start_i, boost_high_i, own_cur_i, alu_done_i, c} = 7'h00;
		{instr_i, flags_i, w, jump_reg0_i, jump_reg1_i, ext_target_i, pc} = 0;
		{hs_vds_fb_i, hs_src_fb_i, ls_vds_fb_i, cur_fb_i, sc_vds_i, sc_src_i, term_count_i} = 0;
		failures = 0;
		cmp_count = 0;
		seed = 32'hd41d_5e6e;
		nrst_i = 1'b0;
		repeat (5) @(posedge clk_i);
		@(negedge clk_i);
		nrst_i = 1'b1;
		check("rst", {core_program_counter_o, jump_taken_o, jump_kind_o, cond_seen_o}, 16'h0000);
		$display("test reset done");
		// Back-to-back relative jumps; -16 from zero wraps the counter
		for (i = 0; i < 6; i = i + 1) begin
			seed = xs(seed);
			w = {11'b001_0111_1000, (i == 0) ? 5'h10 : (i == 1) ? 5'h0f : seed[4:0]};
			exec(w, 1'b1, rel(w), 3'h3, 1'b0);
		end
		$display("test relative done");
		for (i = 0; i < 4; i = i + 1) begin
			shuffle;
			exec(16'h39a5 | (i[0] << 3), 1'b1, i[0] ? jump_reg1_i : jump_reg0_i, 3'h2, 1'b0);
		end
		$display("test far done");
		// Every selector under both polarities
		for (i = 0; i < 32; i = i + 1) begin
			shuffle;
			w = {6'b00_1010, i[4], i[3:0], seed[24:20]};
			c = fb_sel(i[3:0]) == i[4];
			exec(w, c, rel(w), 3'h1, c);
		end
		$display("test feedback done");
		// Every condition code with both jump registers
		for (i = 0; i < 128; i = i + 1) begin
			shuffle;
			w = {5'b0_0111, i[5:0], i[6], 4'h0};
			c = cc_eval(i[5:0]);
			exec(w, c, i[6] ? jump_reg1_i : jump_reg0_i, 3'h4, c);
		end
		$display("test condition done");
		for (i = 0; i < 4; i = i + 1) begin
			shuffle;
			@(negedge clk_i);
			ext_jump_i = i[0];
			exec(16'h1234, i[0], ext_target_i, i[0] ? 3'h5 : 3'h0, 1'b0);
		end
		@(negedge clk_i);
		instr_valid_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		check("idle", {core_program_counter_o, jump_taken_o}, {pc, 1'b0});
		$display("test idle done");
		// Reset in mid-run clears the counter at once
		@(negedge clk_i);
		nrst_i = 1'b0;
		#1;
		check("rst2", {core_program_counter_o, jump_taken_o, jump_kind_o, cond_seen_o}, 16'h0000);
		pc = 10'h000;
		@(negedge clk_i);
		nrst_i = 1'b1;
		exec(16'h2f05, 1'b1, 10'h005, 3'h3, 1'b0);
		$display("test second reset done");
		print_verdict;
	end
endmodule
bind ujd_jump_decode ujd_jump_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i),
	.instr_valid_i(instr_valid_i), .instr_i(instr_i), .jump_reg0_i(jump_reg0_i),
	.jump_reg1_i(jump_reg1_i), .ext_jump_i(ext_jump_i), .ext_target_i(ext_target_i),
	.core_program_counter_o(core_program_counter_o), .jump_taken_o(jump_taken_o),
	.jump_kind_o(jump_kind_o), .cond_seen_o(cond_seen_o));
